/* bcw_cfg_model.sv */
// Purpose: Far side model: configuration memory word and oscillator clock.
// Assumes: The oscillator runs free; it is not a framed link clock.
// Notes: The programmed word always has its reserved bits set.
`timescale 1ns/10ps
`default_nettype none
module bcw_cfg_model (
  input wire logic [31:0] word_i,
  output logic [31:0] cfg_word_o,
  output logic osc_clk_o
);
  ////////////////////////////////////////////////////////////////////////////
  // reserved bits ones
  // The programmer forces bits 13 to 11 high, whatever the bench asks for.
  assign cfg_word_o = word_i | 32'h0000_3800;
  // Free running oscillator, unrelated in phase to the system clock.
  initial begin
    osc_clk_o = 1'b0;
    forever #3.3 osc_clk_o = ~osc_clk_o;
  end
endmodule
`default_nettype wire

/* bcw_decoder.sv */
// Purpose: Decodes the lower fields of configuration word 1 into clock,
//   watchdog and deadman timer settings, readable over AXI4-Lite.
// Assumes: cfg_word_i is stable while rst_n_i is low.
// Notes: The word is sampled every cycle of reset, so the last value held
//   before release is kept until the next reset.
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`include "bcw_regs.svh"
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Postscale code n gives ratio two to n.
// - Codes above 10100 act as 10100.
// - Bit 15 monitor enable, bit 14 switch enable.
// - Bit 10 one turns clock output off.
// - Clock output only when oscillator off or external.
// - Oscillator field: off, crystal, reserved, external.
// - Bit 7 enables two-speed start-up.
// - Bit 6 enables secondary oscillator.
// - Window code n gives (2^n-1)/2^n; zero for 000.
module bcw_decoder (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] cfg_word_i,
  input wire logic osc_clk_i,
  output logic [4:0] watchdog_postscale_sel_o,
  output logic [20:0] watchdog_ratio_o,
  output logic clock_monitor_en_o,
  output logic clock_switch_en_o,
  output logic clock_out_signal_o,
  output logic clock_out_active_o,
  output logic [1:0] primary_oscillator_mode_o,
  output logic posc_disabled_o,
  output logic high_speed_crystal_mode_o,
  output logic external_clock_input_mode_o,
  output logic posc_reserved_o,
  output logic two_speed_startup_en_o,
  output logic secondary_oscillator_en_o,
  output logic [2:0] deadman_window_interval_o,
  output logic [6:0] deadman_window_num_o,
  output logic [7:0] deadman_window_den_o,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Clamps a postscale code to the largest listed value.
  function automatic logic [4:0] clamp_wdt(input logic [4:0] code);
    clamp_wdt = (code > `BCW_WDT_MAX) ? `BCW_WDT_MAX : code;
  endfunction

  // Builds a mask of n ones in an eight bit field.
  function automatic logic [7:0] ones_mask(input logic [2:0] n);
    ones_mask = 8'((9'h001 << n) - 9'h001);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Captured word.

  logic [31:0] cfg_word; // Word held since the last reset.
  logic [31:0] next_cfg_word; // Value loaded at the next edge.
  logic [2:0] load_cnt; // Cycles the word has been captured in this reset, saturating at 7.
  logic [2:0] next_load_cnt; // Next capture count.
  logic in_reset; // Reset was low at the previous edge.
  logic next_in_reset; // Reset level seen at this edge.

  // Loads the word while reset is low; otherwise holds it.
  // The count restarts at one on the first edge of every reset, so it
  // never leans on a value left over from power-up.
  always_comb begin
    next_in_reset = !rst_n_i;
    if (!rst_n_i) begin
      next_cfg_word = cfg_word_i;
      if (in_reset) begin
        next_load_cnt = (load_cnt == 3'h7) ? load_cnt : load_cnt + 3'h1;
      end else begin
        next_load_cnt = 3'h1;
      end
    end else begin
      next_cfg_word = cfg_word;
      next_load_cnt = load_cnt;
    end
  end

  // Registers the word; reset loads the pin value as a clocked capture.
  always_ff @(posedge clk_i) begin
    cfg_word <= next_cfg_word;
    load_cnt <= next_load_cnt;
    in_reset <= next_in_reset;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode, all combinational from the held word.

  logic [4:0] wdt_code; // Clamped postscale code.
  bcw_pkg::bcw_posc_t posc_mode; // Decoded oscillator mode.
  logic clock_out_signal_allowed; // Oscillator permits clock output.
  logic [7:0] dmt_mask; // Ones below the window code, the numerator.

  // Pulls each field out of the held word.
  always_comb begin
    wdt_code = clamp_wdt(cfg_word[`BCW_WDT_HI:`BCW_WDT_LO]);
    posc_mode = bcw_pkg::bcw_posc_t'(cfg_word[`BCW_POSC_HI:`BCW_POSC_LO]);
    clock_out_signal_allowed = (posc_mode == bcw_pkg::BCW_POSC_OFF) ||
                   (posc_mode == bcw_pkg::BCW_POSC_EXT);
    dmt_mask = ones_mask(cfg_word[`BCW_DMT_HI:`BCW_DMT_LO]);
  end

  // Drives the decoded settings.
  always_comb begin
    watchdog_postscale_sel_o = wdt_code;
    watchdog_ratio_o = 21'h00_0001 << wdt_code;
    clock_monitor_en_o = cfg_word[`BCW_CSM_HI];
    clock_switch_en_o = cfg_word[`BCW_CSM_LO];
    clock_out_active_o = !cfg_word[`BCW_CLOCK_OUT_SIGNAL_BIT] && clock_out_signal_allowed;
    primary_oscillator_mode_o = posc_mode;
    posc_disabled_o = (posc_mode == bcw_pkg::BCW_POSC_OFF);
    high_speed_crystal_mode_o = (posc_mode == bcw_pkg::BCW_POSC_HS);
    external_clock_input_mode_o = (posc_mode == bcw_pkg::BCW_POSC_EXT);
    posc_reserved_o = (posc_mode == bcw_pkg::BCW_POSC_RSV);
    two_speed_startup_en_o = cfg_word[`BCW_TWO_SPEED_STARTUP_EN_BIT];
    secondary_oscillator_en_o = cfg_word[`BCW_SOSC_BIT];
    deadman_window_interval_o = cfg_word[`BCW_DMT_HI:`BCW_DMT_LO];
    deadman_window_num_o = dmt_mask[6:0];
    deadman_window_den_o = (deadman_window_interval_o == 3'h0) ? 8'h01 :
      8'(9'h001 << deadman_window_interval_o);
  end

  // Passes the oscillator clock out only when the output is active.
  assign clock_out_signal_o = osc_clk_i & clock_out_active_o;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: read-only word, status, write ignored with error.

  logic aw_held; // Write address taken.
  logic w_held; // Write data taken.
  logic [3:0] aw_addr; // Taken write address.
  logic next_aw_held;
  logic next_w_held;
  logic [3:0] next_aw_addr;
  logic bvalid;
  logic [1:0] bresp;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [31:0] status_word; // Decoded state seen by software.

  // Packs the decoded state for the status register.
  always_comb begin
    status_word = {16'h0000, load_cnt, 5'h00, clock_out_active_o,
                   posc_reserved_o, cfg_word[`BCW_RSV_HI:`BCW_RSV_LO] == 3'h7,
                   wdt_code};
  end

  // Handshake readies.
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;

  // Next state of the write and read channels.
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
    end
    if (next_aw_held && next_w_held && !bvalid) begin
      // All registers are read-only, so every write answers an error.
      next_bvalid = 1'b1;
      next_bresp = `BCW_RESP_SLVERR;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = `BCW_RESP_OK;
      case ({s_axi_araddr[3:2], 2'b00})
        `BCW_OFF_CFG_WORD: begin
          next_rdata = cfg_word;
        end
        `BCW_OFF_STATUS: begin
          next_rdata = status_word;
        end
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = `BCW_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Registers the bus state.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `BCW_RESP_OK;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `BCW_RESP_OK;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  a_word_held: assert property (@(posedge clk_i)
    rst_n_i && $past(rst_n_i) |-> $stable(cfg_word))
    else $error("Held word changed outside reset.");
  a_wdt_clamped: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    cfg_word[20:16] > 5'h14 |-> watchdog_ratio_o == 21'h10_0000 &&
      watchdog_postscale_sel_o == 5'h14)
    else $error("Postscale code above max not clamped.");
  a_wdt_ratio: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    cfg_word[20:16] <= 5'h14 |->
      watchdog_ratio_o == (21'h00_0001 << cfg_word[20:16]))
    else $error("Postscale ratio wrong.");
  a_csm_bits: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    {clock_monitor_en_o, clock_switch_en_o} == cfg_word[15:14])
    else $error("Switch monitor bits wrong.");
  a_clock_out_signal_off: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    cfg_word[10] |-> !clock_out_active_o && !clock_out_signal_o)
    else $error("Clock output on while disabled.");
  a_clock_out_signal_posc: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    clock_out_active_o |-> cfg_word[9:8] != 2'h2 && cfg_word[9:8] != 2'h1)
    else $error("Clock output with crystal mode.");
  a_posc_decode: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    $onehot({posc_disabled_o, high_speed_crystal_mode_o,
             external_clock_input_mode_o, posc_reserved_o}))
    else $error("Oscillator decode not one-hot.");
  a_two_speed_startup_en_bit: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    two_speed_startup_en_o == cfg_word[7])
    else $error("Two-speed start-up wrong.");
  a_sosc_bit: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    secondary_oscillator_en_o == cfg_word[6])
    else $error("Secondary oscillator wrong.");
  a_dmt_window: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    deadman_window_num_o == 7'((8'h01 << cfg_word[5:3]) - 8'h01) &&
      deadman_window_den_o == (8'h01 << cfg_word[5:3]))
    else $error("Deadman window wrong.");
  a_read_answer: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read not answered next cycle.");

  c_clock_out_signal_active: cover property (@(posedge clk_i) clock_out_active_o);
  c_wdt_clamp: cover property (@(posedge clk_i) cfg_word[20:16] > 5'h14);
  c_read_done: cover property (@(posedge clk_i) s_axi_rvalid && s_axi_rready);
  c_write_err: cover property (@(posedge clk_i) s_axi_bvalid);

endmodule
`default_nettype wire

/* bcw_pkg.sv */
// Purpose: Types shared by the boot word decoder.
// Assumes: Constants live in bcw_regs.svh.
// Notes: No imports are used anywhere.
`default_nettype none
package bcw_pkg;
  // Primary oscillator mode encodings.
  typedef enum logic [1:0] {
    BCW_POSC_EXT = 2'h0,
    BCW_POSC_RSV = 2'h1,
    BCW_POSC_HS = 2'h2,
    BCW_POSC_OFF = 2'h3
  } bcw_posc_t;
endpackage
`default_nettype wire

/* bcw_regs.svh */
// Purpose: Offsets, field positions and reset values for the boot word decoder.
// Assumes: Registers sit on a 32-bit AXI4-Lite bus, one word each.
// Notes: Definitions only; included by its bare name.
`ifndef BCW_REGS_SVH
`define BCW_REGS_SVH

// Register byte offsets.
`define BCW_OFF_CFG_WORD 4'h0
`define BCW_OFF_STATUS 4'h4
`define BCW_OFF_RELOAD 4'h8

// Field positions inside the configuration word.
`define BCW_WDT_HI 20
`define BCW_WDT_LO 16
`define BCW_CSM_HI 15
`define BCW_CSM_LO 14
`define BCW_RSV_HI 13
`define BCW_RSV_LO 11
`define BCW_CLOCK_OUT_SIGNAL_BIT 10
`define BCW_POSC_HI 9
`define BCW_POSC_LO 8
`define BCW_TWO_SPEED_STARTUP_EN_BIT 7
`define BCW_SOSC_BIT 6
`define BCW_DMT_HI 5
`define BCW_DMT_LO 3

// Largest listed postscale code.
`define BCW_WDT_MAX 5'h14

// Unused word value (reset loads the captured word from the pins) and the AXI OK and error answers.
`define BCW_WORD_RST 32'h0000_0000
`define BCW_RESP_OK 2'h0
`define BCW_RESP_SLVERR 2'h2

`endif

/* tb_boot_config_word_decoder.sv */
// Purpose: Self-checking bench for the boot word decoder.
// Assumes: Writes answer with an error; reads answer one cycle after AR.
// Notes: Every postscale, oscillator and window code is swept, each with its own reset.
`include "bcw_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_boot_config_word_decoder;
  logic clk_i, rst_n_i, osc;
  logic [31:0] word, cfg, wdata, rdata, d, w;
  logic [3:0] awaddr, araddr, wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, aw, wd;
  logic [1:0] bresp, rresp, r;
  logic [4:0] psel;
  logic [20:0] ratio;
  logic mon, sw, clock_out_signal, act, pd, hs, ec, pr, ts, so;
  logic [1:0] mode;
  logic [2:0] dint;
  logic [6:0] num;
  logic [7:0] den;
  int fail_count, tests_run, cycles, seed;
  bcw_cfg_model bcw_cfg_model_inst (.word_i(word), .cfg_word_o(cfg),
    .osc_clk_o(osc));
  bcw_decoder bcw_decoder_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cfg_word_i(cfg), .osc_clk_i(osc), .watchdog_postscale_sel_o(psel),
    .watchdog_ratio_o(ratio), .clock_monitor_en_o(mon),
    .clock_switch_en_o(sw), .clock_out_signal_o(clock_out_signal),
    .clock_out_active_o(act), .primary_oscillator_mode_o(mode),
    .posc_disabled_o(pd), .high_speed_crystal_mode_o(hs),
    .external_clock_input_mode_o(ec), .posc_reserved_o(pr),
    .two_speed_startup_en_o(ts), .secondary_oscillator_en_o(so),
    .deadman_window_interval_o(dint), .deadman_window_num_o(num),
    .deadman_window_den_o(den), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ////////////////////////////////////////////////////////////////////////////
  // Clock at 250 MHz.
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Prints the counts and the verdict, then ends the run.
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // A hang is counted as a mismatch.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run;
    end
  end
  // Compares one value with its expectation.
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // One AXI read; ready is held from the start until the answer.
  task rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] p);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    v = rdata;
    p = rresp;
    rready <= 1'b0;
    @(posedge clk_i);
  endtask
  // One AXI write; address and data are released as each is taken.
  task wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] p);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1'b0;
    wd = 1'b0;
    do begin
      @(posedge clk_i);
      if (awready === 1'b1 && !aw) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !wd) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw && wd));
    do @(posedge clk_i); while (bvalid !== 1'b1);
    p = bresp;
    bready <= 1'b0;
    @(posedge clk_i);
  endtask
  // Checks every decoded output against the model of word e.
  task chk_out(input logic [31:0] e);
    int c, n;
    logic a;
    c = e[20:16] > 20 ? 20 : e[20:16];
    n = e[5:3];
    a = !e[10] && (e[9:8] == 2'h3 || e[9:8] == 2'h0);
    chk("postscale", psel, c);
    chk("ratio", ratio, 1 << c);
    chk("monitor", {mon, sw}, e[15:14]);
    chk("clk_active", act, a);
    chk("posc", {mode, pd, hs, ec, pr}, {e[9:8], e[9:8] == 2'h3,
      e[9:8] == 2'h2, e[9:8] == 2'h0, e[9:8] == 2'h1});
    chk("startup", {ts, so}, e[7:6]);
    chk("deadman", {dint, num, den}, {e[5:3], 7'((1 << n) - 1),
      8'(1 << n)});
    chk("status", rd_status(e), {16'h0, 3'h7, 5'h00, a, e[9:8] == 2'h1,
      1'b1, 5'(c)});
    @(posedge osc) #0.5;
    chk("clk_out_hi", clock_out_signal, a);
    @(negedge osc) #0.5;
    chk("clk_out_lo", clock_out_signal, 32'h0000_0000);
    // Back onto the system clock edge before the next bus request.
    @(posedge clk_i);
  endtask
  // Returns the status word last read into d, keeping its low half; a long reset saturates the count.
  function automatic logic [31:0] rd_status(input logic [31:0] e);
    return d & 32'h0000_ffff;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: sweep all postscale, oscillator and window codes, each under its own reset.
  initial begin
    seed = 32'hd33025fb;
    {awaddr, araddr, wstrb, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    rst_n_i = 1'b0;
    word = $random(seed);
    repeat (20) @(posedge clk_i);
    for (int i = 0; i < 32; i++) begin
      w = $random(seed);
      w[20:16] = 5'(i);
      w[9:8] = 2'(i);
      w[5:3] = 3'(i >> 2);
      rst_n_i <= 1'b0;
      word <= w;
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      word <= ~w;
      repeat (3) @(posedge clk_i);
      w = w | 32'h0000_3800;
      rd(`BCW_OFF_STATUS, d, r);
      chk_out(w);
      rd(`BCW_OFF_CFG_WORD, d, r);
      chk("word", d, w);
      chk("resp", r, `BCW_RESP_OK);
      wr(4'(4 * (i % 3)), $random(seed), r);
      chk("wr_resp", r, `BCW_RESP_SLVERR);
      rd(`BCW_OFF_RELOAD, d, r);
      chk("unmapped", d, 32'h0000_0000);
      chk("unmapped_resp", {30'h0, r}, {30'h0, `BCW_RESP_SLVERR});
      rd(`BCW_OFF_CFG_WORD, d, r);
      chk("word_kept", d, w);
    end
    complete_run;
  end
endmodule
`default_nettype wire
